// ===== hw/utl_ctrl.sv
/*
 * usb link control: test modes, forced role and speed, receive endpoint
 * polling and nak limit, fifo sizing, l1 link power handshake.
 * assumes a single 25 MHz clock, a plain register port and a link engine
 * that presents decoded token events one cycle wide.
 */
// What this block does
// - force-host bit puts controller in host role regardless of attachment
// - loopback bit copies ep0 transmit packet to ep0 receive, then self-clears
// - under force-host: hs bit high, fs bit alone full speed, neither low
// - high speed with packet bit repeats 53-byte test packet
// - high speed with k bit drives continuous k until cleared
// - high speed with j bit drives continuous j until cleared
// - se0_nak mode stays high speed and naks every valid in token
// - low/full interrupt polling interval is m frames, m 1..255
// - high-speed interrupt and isochronous interval is 2^(m-1), m 1..16
// - bulk nak timeout is 2^(m-1); m of 0 or 1 disables it
// - speed field: 11 low, 10 full, 01 high, 00 reserved
// - protocol field: 00 control, 01 iso, 10 bulk, 11 interrupt
// - fifo size code n gives 8*2^n bytes; 1010 and up reserved
// - double buffer bit doubles that direction's allocated space
// - device: lpm with tx fifos empty gives ack, clears request, interrupts
// - device: lpm with data pending gives nyet, keeps request, interrupts
// - host: l1 request sends lpm; clears on any token or three timeouts
// - resume time is 50 us plus field times 75 us
// - lpm link state must be 1 (l1 sleep)
`include "utl_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module utl_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire utl_pkg::utl_bus_t bus,
	output logic [31:0] rdata,
	// endpoint zero fifo side
	input wire logic [7:0] ep0_tx_byte,
	input wire logic tx_fifos_empty,
	output logic [5:0] ep0_tx_addr,
	output logic ep0_loop_go,
	// link side
	input wire utl_pkg::utl_link_in_t link_in,
	output utl_pkg::utl_link_out_t link_out,
	// status to the core
	output logic host_role,
	output logic [1:0] link_speed,
	output logic lpm_irq,
	output logic resume_active,
	output logic [13:0] rx_alloc_bytes,
	output logic [13:0] tx_alloc_bytes,
	output logic [16:0] rx_interval,
	output logic rx_nak_timeout_en
);
	import utl_pkg::*;

	// register copies
	logic [31:0] test_r;
	logic [15:0] rxep_r;
	logic [31:0] otg_r;
	logic [31:0] lpm_r;
	logic [31:0] rdata_r;
	logic irq_r;
	logic [1:0] tmo_cnt_r;
	logic [5:0] pkt_idx_r;
	logic lpm_sent_r;
	logic [14:0] resume_cnt_r;
	logic resume_go;
	logic [14:0] resume_len;
	logic hs;
	logic hs_k;
	logic hs_j;
	logic hs_pkt;
	logic hs_nak;

	// decoded strobes and conditions
	logic wr_test;
	logic wr_rxep;
	logic wr_otg;
	logic wr_lpm;
	logic dev_lpm_hit;
	logic dev_ack_clear;
	logic host_clear;
	logic host_lpm_due;
	logic [7:0] rx_m;
	logic [1:0] rx_spd;
	logic [1:0] rx_prot;
	logic [31:0] status_word;

	// link output flops
	logic line_drive_r;
	utl_line_t line_r;
	logic pkt_valid_r;
	logic [7:0] pkt_byte_r;
	utl_hshake_t hshake_r;
	logic hshake_valid_r;
	logic lpm_send_r;

	// size code to bytes, doubled when double buffered
	// reserved codes allocate nothing rather than wrapping the shift
	function automatic logic [13:0] fifo_bytes(input logic [3:0] code, input logic dbl);
		logic [13:0] b;
		b = (code > `UTL_SZ_MAX) ? 14'h0000 : (14'h0008 << code);
		fifo_bytes = dbl ? {b[12:0], 1'b0} : b;
	endfunction : fifo_bytes

	// 2^(m-1) for m in 1..16, else zero
	// an out-of-range m gives zero, which reads as interval off
	function automatic logic [16:0] pow_m(input logic [7:0] m);
		pow_m = (m == 8'h00 || m > 8'h10) ? 17'h00000 : (17'h00001 << (m - 8'h01));
	endfunction : pow_m

	// write strobe aimed at one register word
	function automatic logic reg_hit(input utl_bus_t b, input logic [3:0] off);
		reg_hit = b.wr && (b.addr == off);
	endfunction : reg_hit

	assign wr_test = reg_hit(bus, `UTL_OFF_TEST);
	assign wr_rxep = reg_hit(bus, `UTL_OFF_RXEP);
	assign wr_otg = reg_hit(bus, `UTL_OFF_OTG);
	assign wr_lpm = reg_hit(bus, `UTL_OFF_LPM);

	// unforced speed is reported as high; the link engine settles the real one

	assign host_role = test_r[`UTL_B_FORCE_HOST];
	always_comb begin
		if (!test_r[`UTL_B_FORCE_HOST])
			link_speed = `UTL_SPD_HIGH;
		else if (test_r[`UTL_B_FORCE_HS])
			link_speed = `UTL_SPD_HIGH;
		else if (test_r[`UTL_B_FORCE_FS])
			link_speed = `UTL_SPD_FULL;
		else
			link_speed = `UTL_SPD_LOW;
	end
	assign hs = (link_speed == `UTL_SPD_HIGH);
	// test modes act only at high speed
	assign hs_k = hs && test_r[`UTL_B_TEST_K];
	assign hs_j = hs && test_r[`UTL_B_TEST_J];
	assign hs_pkt = hs && test_r[`UTL_B_PACKET];
	assign hs_nak = hs && test_r[`UTL_B_SE0_NAK];

	// test register, loopback bit clears itself after one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_r <= 32'h00000000;
		end else if (wr_test) begin
			// frame number and unimplemented bits are not stored and read zero
			test_r <= {bus.wdata[31:24], 4'h0, bus.wdata[19:16], 16'h0000};
		end else if (test_r[`UTL_B_LOOPBACK]) begin
			test_r[`UTL_B_LOOPBACK] <= 1'b0;
		end
	end
	assign ep0_loop_go = test_r[`UTL_B_LOOPBACK];

	// receive endpoint config: interval, speed, protocol, target
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rxep_r <= 16'h0000;
		else if (wr_rxep)
			rxep_r <= bus.wdata[15:0];
	end
	// target endpoint is kept for software only
	assign rx_m = rxep_r[15:8];
	assign rx_spd = rxep_r[7:6];
	assign rx_prot = rxep_r[5:4];
	always_comb begin
		rx_interval = 17'h00000;
		rx_nak_timeout_en = 1'b0;
		case (rx_prot)
			`UTL_PROT_INT: begin
				if (rx_spd == `UTL_SPD_HIGH)
					rx_interval = pow_m(rx_m);
				else
					rx_interval = {9'h000, rx_m};
			end
			`UTL_PROT_ISO: rx_interval = pow_m(rx_m);
			`UTL_PROT_BULK: begin
				rx_nak_timeout_en = (rx_m > 8'h01);
				rx_interval = rx_nak_timeout_en ? pow_m(rx_m) : 17'h00000;
			end
			default: rx_interval = 17'h00000;
		endcase
	end

	// otg fifo sizing register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			otg_r <= 32'h00000000;
		else if (wr_otg)
			otg_r <= {3'h0, bus.wdata[28:24], 3'h0, bus.wdata[20:16], 16'h0000};
	end
	// space set aside per direction
	assign rx_alloc_bytes = fifo_bytes(otg_r[27:24], otg_r[`UTL_B_RX_DPB]);
	assign tx_alloc_bytes = fifo_bytes(otg_r[19:16], otg_r[`UTL_B_TX_DPB]);

	// a device lpm answer is due once request and enable 11 stand together
	assign dev_lpm_hit = !host_role && lpm_r[`UTL_B_L1_REQ] && link_in.lpm_token
		&& lpm_r[19:18] == `UTL_LPM_EN_ARM;
	// ack clears the request only for a well formed l1 request; nyet keeps it armed
	assign dev_ack_clear = dev_lpm_hit && link_in.link_state == `UTL_LINK_L1
		&& tx_fifos_empty;
	assign host_clear = host_role && lpm_sent_r && (link_in.any_token
		|| (link_in.timeout && tmo_cnt_r == `UTL_LPM_TIMEOUTS - 2'h1));

	// link power register with l1 request handshake
	// endpoint, remote wake and link state are plain storage; the resume field sets the resume timer length
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lpm_r <= 32'h00000000;
		end else if (wr_lpm) begin
			lpm_r <= {12'h000, bus.wdata[19:16], bus.wdata[15:12], 3'h0, bus.wdata[8:0]};
		end else if (dev_ack_clear || host_clear) begin
			lpm_r[`UTL_B_L1_REQ] <= 1'b0;
		end
	end

	// host side: the transaction counts as sent one cycle after the request rises
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lpm_sent_r <= 1'b0;
		else
			lpm_sent_r <= host_role && lpm_r[`UTL_B_L1_REQ];
	end
	assign host_lpm_due = host_role && lpm_r[`UTL_B_L1_REQ] && !lpm_sent_r;

	// host side: timeouts counted while the request waits; a new request restarts the count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tmo_cnt_r <= 2'h0;
		else if (!host_role || !lpm_r[`UTL_B_L1_REQ])
			tmo_cnt_r <= 2'h0;
		else if (link_in.timeout)
			tmo_cnt_r <= tmo_cnt_r + 2'h1;
	end

	// interrupt pulse on every armed device lpm answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_r <= 1'b0;
		else
			irq_r <= dev_lpm_hit;
	end
	assign lpm_irq = irq_r;

	// resume drive timer, loaded by the token that ends a sent host request
	assign resume_len = 15'(`UTL_RESUME_BASE_CYC)
		+ 15'(lpm_r[7:4]) * 15'(`UTL_RESUME_STEP_CYC);
	assign resume_go = host_role && lpm_r[`UTL_B_L1_REQ] && link_in.any_token && lpm_sent_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			resume_cnt_r <= 15'h0000;
		else if (resume_go)
			resume_cnt_r <= resume_len;
		else if (resume_cnt_r != 15'h0000)
			resume_cnt_r <= resume_cnt_r - 15'h0001;
	end
	assign resume_active = (resume_cnt_r != 15'h0000);

	// test packet byte index wraps for repetition
	// index restarts at byte zero whenever the mode drops out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pkt_idx_r <= 6'h00;
		else if (!hs_pkt)
			pkt_idx_r <= 6'h00;
		else if (pkt_idx_r == `UTL_TEST_PKT_BYTES - 6'h01)
			pkt_idx_r <= 6'h00;
		else
			pkt_idx_r <= pkt_idx_r + 6'h01;
	end
	assign ep0_tx_addr = pkt_idx_r;

	// line level test modes, k takes precedence over j and the packet
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_drive_r <= 1'b0;
			line_r <= UTL_LS_SE0;
		end else if (hs_k) begin
			line_drive_r <= 1'b1;
			line_r <= UTL_LS_K;
		end else if (hs_j) begin
			line_drive_r <= 1'b1;
			line_r <= UTL_LS_J;
		end else if (hs_pkt) begin
			line_drive_r <= 1'b1;
			line_r <= UTL_LS_SE0;
		end else begin
			line_drive_r <= 1'b0;
			line_r <= UTL_LS_SE0;
		end
	end

	// test packet stream; pkt_byte trails ep0_tx_addr by one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pkt_valid_r <= 1'b0;
			pkt_byte_r <= 8'h00;
		end else if (hs_pkt && !hs_k && !hs_j) begin
			pkt_valid_r <= 1'b1;
			pkt_byte_r <= ep0_tx_byte;
		end else begin
			pkt_valid_r <= 1'b0;
			pkt_byte_r <= 8'h00;
		end
	end

	// handshake answers; se0_nak goes before the lpm answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hshake_r <= UTL_HS_NONE;
			hshake_valid_r <= 1'b0;
		end else if (hs_nak && link_in.in_token) begin
			hshake_r <= UTL_HS_NAK;
			hshake_valid_r <= 1'b1;
		end else if (dev_lpm_hit) begin
			hshake_r <= tx_fifos_empty ? UTL_HS_ACK : UTL_HS_NYET;
			hshake_valid_r <= 1'b1;
		end else begin
			hshake_r <= UTL_HS_NONE;
			hshake_valid_r <= 1'b0;
		end
	end

	// host lpm transaction goes out once per request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lpm_send_r <= 1'b0;
		else
			lpm_send_r <= host_lpm_due;
	end

	// link output word; the link state is l1 while a transaction goes out
	always_comb begin
		link_out = '0;
		link_out.drive = line_drive_r;
		link_out.line = line_r;
		link_out.pkt_byte = pkt_byte_r;
		link_out.pkt_valid = pkt_valid_r;
		link_out.hshake = hshake_r;
		link_out.hshake_valid = hshake_valid_r;
		link_out.lpm_send = lpm_send_r;
		link_out.lpm_link_state = lpm_send_r ? `UTL_LINK_L1 : 4'h0;
	end

	// status word: resume, speed, role and transmit allocation
	always_comb begin
		status_word = 32'h00000000;
		status_word[18] = resume_active;
		status_word[17:16] = link_speed;
		status_word[15] = host_role;
		status_word[14:1] = tx_alloc_bytes;
	end

	// read data one cycle after the strobe; idle cycles and unmapped words read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h00000000;
		end else if (bus.rd) begin
			case (bus.addr)
				`UTL_OFF_TEST: rdata_r <= test_r;
				`UTL_OFF_RXEP: rdata_r <= {16'h0000, rxep_r};
				`UTL_OFF_OTG: rdata_r <= otg_r;
				`UTL_OFF_LPM: rdata_r <= lpm_r;
				`UTL_OFF_STAT: rdata_r <= status_word;
				default: rdata_r <= 32'h00000000;
			endcase
		end else begin
			rdata_r <= 32'h00000000;
		end
	end
	assign rdata = rdata_r;
endmodule : utl_ctrl

`default_nettype wire

// ===== hw/utl_defines.svh
/*
 * register offsets, field positions, codes and timing counts of the
 * usb test / link power / endpoint control block.
 * assumes a 25 MHz clock and a plain strobe register port.
 */
`ifndef UTL_DEFINES_SVH
`define UTL_DEFINES_SVH

// register word offsets on the plain port
`define UTL_OFF_TEST 4'h0
`define UTL_OFF_RXEP 4'h1
`define UTL_OFF_OTG 4'h2
`define UTL_OFF_LPM 4'h3
`define UTL_OFF_STAT 4'h4

// test register bits
`define UTL_B_FORCE_HOST 31
`define UTL_B_LOOPBACK 30
`define UTL_B_FORCE_FS 29
`define UTL_B_FORCE_HS 28
`define UTL_B_PACKET 27
`define UTL_B_TEST_K 26
`define UTL_B_TEST_J 25
`define UTL_B_SE0_NAK 24

// otg fifo register bits
`define UTL_B_RX_DPB 28
`define UTL_B_TX_DPB 20
`define UTL_SZ_MAX 4'h9

// link power register bits
`define UTL_B_L1_REQ 16
`define UTL_LPM_EN_ARM 2'h3
`define UTL_LINK_L1 4'h1
`define UTL_LPM_TIMEOUTS 2'h3

// speed and protocol codes of the receive endpoint
`define UTL_SPD_LOW 2'h3
`define UTL_SPD_FULL 2'h2
`define UTL_SPD_HIGH 2'h1
`define UTL_PROT_CTRL 2'h0
`define UTL_PROT_ISO 2'h1
`define UTL_PROT_BULK 2'h2
`define UTL_PROT_INT 2'h3

// test packet and resume timing
`define UTL_TEST_PKT_BYTES 6'd53
`define UTL_CLK_MHZ 25
`define UTL_RESUME_BASE_US 50
`define UTL_RESUME_STEP_US 75
`define UTL_RESUME_BASE_CYC (`UTL_RESUME_BASE_US * `UTL_CLK_MHZ)
`define UTL_RESUME_STEP_CYC (`UTL_RESUME_STEP_US * `UTL_CLK_MHZ)

`endif

// ===== hw/utl_pkg.sv
/*
 * types of the usb test / link power / endpoint control block.
 * assumes nothing beyond the defines header.
 */
package utl_pkg;
	typedef enum logic [1:0] {
		UTL_LS_J = 2'h1,
		UTL_LS_K = 2'h2,
		UTL_LS_SE0 = 2'h0
	} utl_line_t;

	typedef enum logic [1:0] {
		UTL_HS_NONE = 2'h0,
		UTL_HS_ACK = 2'h1,
		UTL_HS_NYET = 2'h2,
		UTL_HS_NAK = 2'h3
	} utl_hshake_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} utl_bus_t;

	typedef struct packed {
		logic in_token;
		logic lpm_token;
		logic any_token;
		logic timeout;
		logic [3:0] link_state;
	} utl_link_in_t;

	typedef struct packed {
		logic drive;
		utl_line_t line;
		logic [7:0] pkt_byte;
		logic pkt_valid;
		utl_hshake_t hshake;
		logic hshake_valid;
		logic lpm_send;
		logic [3:0] lpm_link_state;
	} utl_link_out_t;
endpackage : utl_pkg

// ===== verif/tb_top.sv
/* self-checking bench of utl_ctrl; partner on the link, checker bound in */
`include "utl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import utl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic tfe = 1'b1;
	logic rd_d = 1'b0;
	utl_bus_t bus = '0;
	logic [31:0] rdata;
	logic [5:0] addr;
	logic [7:0] tx_byte;
	utl_link_in_t lin;
	utl_link_out_t lout;
	logic [1:0] spd;
	logic host, irq, res, nak_en;
	logic [13:0] rxa, txa;
	logic [16:0] ivl;
	int bad_count = 0;
	int samples_checked = 0;
	logic [31:0] rd_q[$];
	utl_hshake_t hs_q[$];
	always #20 clk = ~clk;
	utl_ctrl utl_ctrl_i (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.ep0_tx_byte(tx_byte), .tx_fifos_empty(tfe), .ep0_tx_addr(addr),
		.ep0_loop_go(), .link_in(lin), .link_out(lout), .host_role(host),
		.link_speed(spd), .lpm_irq(irq), .resume_active(res),
		.rx_alloc_bytes(rxa), .tx_alloc_bytes(txa), .rx_interval(ivl),
		.rx_nak_timeout_en(nak_en));
	utl_link_partner utl_link_partner_i (.clk(clk), .ep0_tx_addr(addr),
		.ep0_tx_byte(tx_byte), .link_in(lin));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk) bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk) bus <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0};
		rd_q.push_back(e);
		@(posedge clk) bus <= '0;
		#1;
	endtask : rd
	// results are matched against the oldest note
	always @(posedge clk) begin
		if (rd_d === 1'b1)
			check(rdata, rd_q.pop_front());
		if (lout.hshake_valid === 1'b1)
			check(lout.hshake, hs_q.pop_front());
		rd_d <= bus.rd;
	end
	initial begin
		int n;
		logic [31:0] v;
		void'($urandom(32'hb180));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(`UTL_OFF_STAT, 32'h0001_0010);
		rd(4'h7, 32'h0);
		for (int s = 0; s < 3; s++) begin
			// never both speed bits at once
			v = 32'h8003_0000 | (32'(s) << 28);
			wr(`UTL_OFF_TEST, v);
			rd(`UTL_OFF_TEST, v);
			rd(`UTL_OFF_STAT, {14'h0, 2'(s == 0 ? 3 : s), 1'b1, 14'h8, 1'b0});
		end
		wr(`UTL_OFF_TEST, 32'h4000_0000);
		rd(`UTL_OFF_TEST, 32'h0);
		$display("done role speed loopback");
		wr(`UTL_OFF_TEST, 32'h0100_0000);
		hs_q.push_back(UTL_HS_NAK);
		utl_link_partner_i.send(2'h0, 4'h1);
		for (int k = 0; k < 2; k++) begin
			wr(`UTL_OFF_TEST, 32'h0400_0000 >> k);
			repeat (2) @(posedge clk);
			check({lout.drive, lout.line}, {1'b1, k ? UTL_LS_J : UTL_LS_K});
		end
		wr(`UTL_OFF_TEST, 32'h0800_0000);
		repeat (3) @(posedge clk);
		v = addr;
		repeat (60) begin
			@(posedge clk);
			check({lout.pkt_valid, lout.pkt_byte}, {1'b1, {2'h2, v[5:0]} ^ 8'h3C});
			check(addr, v[5:0] == 6'd52 ? 6'd0 : v[5:0] + 6'd1);
			v = addr;
		end
		$display("done test modes");
		for (int p = 0; p < 4; p++)
			for (int s = 1; s < 4; s++) begin
				n = s == 3 ? 16 : s == 2 ? 1 : 1 + $urandom % 16;
				v = {16'h0, 8'(n), 2'(s), 2'(p), 4'h5};
				wr(`UTL_OFF_RXEP, v);
				rd(`UTL_OFF_RXEP, v);
				if (p == 2)
					check(nak_en, n > 1);
				else if (p == 3 && s > 1)
					check(ivl, n);
				else if (p == 3 || (p == 1 && s < 3))
					check(ivl, 1 << (n - 1));
			end
		for (int c = 0; c < 12; c++) begin
			v = $urandom;
			v = {3'h0, v[0], 4'(c), 3'h0, v[1], 4'(11 - c), 16'h0};
			wr(`UTL_OFF_OTG, v);
			check(rxa, c > 9 ? 0 : (8 << c) << v[28]);
			check(txa, c < 2 ? 0 : (8 << (11 - c)) << v[20]);
		end
		$display("done endpoint and sizing");
		wr(`UTL_OFF_TEST, 32'h0);
		for (int e = 0; e < 2; e++) begin
			@(posedge clk) tfe <= e == 0;
			wr(`UTL_OFF_LPM, 32'h000D_0001);
			hs_q.push_back(e ? UTL_HS_NYET : UTL_HS_ACK);
			utl_link_partner_i.send(2'h1, 4'h1);
			rd(`UTL_OFF_LPM, 32'h000C_0001 | (e << 16));
		end
		@(posedge clk) tfe <= 1'b1;
		wr(`UTL_OFF_LPM, 32'h0);
		wr(`UTL_OFF_TEST, 32'h8000_0000);
		wr(`UTL_OFF_LPM, 32'h0001_0011);
		repeat (2) utl_link_partner_i.send(2'h3, 4'h1);
		rd(`UTL_OFF_LPM, 32'h0001_0011);
		utl_link_partner_i.send(2'h3, 4'h1);
		rd(`UTL_OFF_LPM, 32'h0000_0011);
		wr(`UTL_OFF_LPM, 32'h0001_0011);
		utl_link_partner_i.send(2'h2, 4'h1);
		n = 0;
		while (res === 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		check(n > 3122 && n < 3130, 1'b1);
		if (n >= 4000)
			print_verdict();
		rd(`UTL_OFF_LPM, 32'h0000_0011);
		$display("done link power");
		repeat (3) @(posedge clk);
		check(rd_q.size() + hs_q.size(), 0);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

// ===== verif/utl_link_partner.sv
/* far side of the link: token events and ep0 bytes; the bench calls send */
`timescale 1ns/1ns
`default_nettype none
module utl_link_partner (
	// clock
	input wire logic clk,
	// ep0 fifo
	input wire logic [5:0] ep0_tx_addr,
	output logic [7:0] ep0_tx_byte,
	// link events
	output utl_pkg::utl_link_in_t link_in
);
	import utl_pkg::*;
	// packet is in place before any test mode
	assign ep0_tx_byte = {2'h2, ep0_tx_addr} ^ 8'h3C;
	initial link_in = '0;
	// k: 0 in, 1 lpm, 2 any token, 3 timeout; l1 state sent
	task automatic send(input logic [1:0] k, input logic [3:0] st);
		@(posedge clk);
		link_in <= {4'h8 >> k, st};
		@(posedge clk);
		link_in <= {4'h0, ~st};
		@(posedge clk);
	endtask : send
endmodule : utl_link_partner
`default_nettype wire

// ===== verif/utl_monitor.sv
/* checker of the utl_ctrl ports; bound to every utl_ctrl instance */
`include "utl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module utl_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// watched ports
	input wire utl_pkg::utl_bus_t bus,
	input wire logic tx_fifos_empty,
	input wire logic ep0_loop_go,
	input wire utl_pkg::utl_link_in_t link_in,
	input wire utl_pkg::utl_link_out_t link_out,
	input wire logic host_role,
	input wire logic [1:0] link_speed,
	input wire logic lpm_irq,
	input wire logic [13:0] rx_alloc_bytes
);
	import utl_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] t_r;
	logic [31:0] o_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) t_r <= 32'h0;
		else if (bus.wr && bus.addr == `UTL_OFF_TEST) t_r <= bus.wdata;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) o_r <= 32'h0;
		else if (bus.wr && bus.addr == `UTL_OFF_OTG) o_r <= bus.wdata;
	end
	sequence s_wr(a);
		bus.wr && bus.addr == a;
	endsequence
	property p_role;
		s_wr(`UTL_OFF_TEST) |=> host_role == $past(bus.wdata[31]);
	endproperty
	a_role: assert property (p_role) else $error("host role mismatch");
	property p_loop;
		s_wr(`UTL_OFF_TEST) ##0 bus.wdata[30] |=> ep0_loop_go ##1 !ep0_loop_go;
	endproperty
	a_loop: assert property (p_loop) else $error("loopback pulse wrong");
	property p_spd;
		s_wr(`UTL_OFF_TEST) ##0 bus.wdata[31] |=> link_speed == ($past(bus.wdata[29]) ?
			`UTL_SPD_FULL : $past(bus.wdata[28]) ? `UTL_SPD_HIGH : `UTL_SPD_LOW);
	endproperty
	a_spd: assert property (p_spd) else $error("forced speed wrong");
	property p_nak;
		link_in.in_token && t_r[24] && link_speed == `UTL_SPD_HIGH
			|=> link_out.hshake_valid && link_out.hshake == UTL_HS_NAK;
	endproperty
	a_nak: assert property (p_nak) else $error("in token not refused");
	property p_k;
		t_r[26] && link_speed == `UTL_SPD_HIGH |=> link_out.drive && link_out.line == UTL_LS_K;
	endproperty
	a_k: assert property (p_k) else $error("k level missing");
	property p_ack;
		lpm_irq && $past(tx_fifos_empty) |-> link_out.hshake_valid && link_out.hshake == UTL_HS_ACK;
	endproperty
	a_ack: assert property (p_ack) else $error("lpm ack missing");
	property p_nyet;
		lpm_irq && !$past(tx_fifos_empty) |-> link_out.hshake_valid && link_out.hshake == UTL_HS_NYET;
	endproperty
	a_nyet: assert property (p_nyet) else $error("lpm nyet missing");
	property p_send;
		s_wr(`UTL_OFF_LPM) ##0 bus.wdata[16] && host_role
			|-> ##2 link_out.lpm_send && link_out.lpm_link_state == `UTL_LINK_L1;
	endproperty
	a_send: assert property (p_send) else $error("lpm not sent");
	property p_alloc;
		rx_alloc_bytes == ((o_r[27:24] > 4'h9) ? 14'h0 : (14'h8 << o_r[27:24]) << o_r[28]);
	endproperty
	a_alloc: assert property (p_alloc) else $error("rx space wrong");
endmodule : utl_monitor
bind utl_ctrl utl_monitor utl_monitor_i (.clk(clk), .rst_n(rst_n), .bus(bus),
	.tx_fifos_empty(tx_fifos_empty), .ep0_loop_go(ep0_loop_go), .link_in(link_in),
	.link_out(link_out), .host_role(host_role), .link_speed(link_speed),
	.lpm_irq(lpm_irq), .rx_alloc_bytes(rx_alloc_bytes));
`default_nettype wire
